// ---- rom_select_cacheability_irq_latch_test.sv ----
/* Self-checking bench for the register bank: APB tasks and host cycles.
   Assumes rscl_top, rscl_host_model and the checker are compiled first. */
`timescale 1ns/10ps
module rom_select_cacheability_irq_latch_test;
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic kin, min, kout, mout, rom_n, l1c;
  logic [3:0] strb;
  logic [31:0] paddr, pwdata, prdata, q;
  rscl_pkg::rscl_cycle_type hc;
  int miscompares, total_checks, i;
  rscl_top rscl_top_inst (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .host_cycle_active(hc.active),
    .host_cycle_is_io(hc.is_io), .host_cycle_is_write(hc.is_write),
    .host_cycle_addr(hc.addr), .mouse_interrupt_in(min), .keyboard_interrupt_in(kin),
    .mouse_interrupt(mout), .keyboard_interrupt(kout), .rom_select_n(rom_n),
    .l1_cacheable(l1c));
  rscl_host_model rscl_host_model_inst (.clk(clk), .cyc(hc));
  task test_done;
    if (miscompares == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // One APB transfer; read data lands in q, the error flag in err
  task apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {22'h0, idx, 2'h0};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n == 20) begin
      miscompares++;
      test_done;
    end
    q = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task hchk(input logic a, io, w, input logic [31:0] ad, input logic er, el);
    rscl_host_model_inst.go(a, io, w, ad);
    #1;
    chk({rom_n, l1c}, {er, el});
  endtask
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  initial begin
    {reset_n, psel, penable, pwrite, kin, min} = '0;
    paddr = '0;
    pwdata = '0;
    strb = 4'hF;
    miscompares = 0;
    total_checks = 0;
    repeat (12) @(posedge clk);
    reset_n <= 1'h1;
    apb(1'h0, 8'h2D, '0);
    chk(q, 32'h000000C0);
    apb(1'h0, 8'h10, '0);
    chk(err, 32'h00000001);
    for (i = 0; i < 6; i++) begin
      apb(1'h1, 8'h2D, 32'h000000C0 | (32'h00000001 << i));
      hchk(1'h1, 1'h0, 1'h0, 32'h000C0000 + i * 32'h00008000, 1'h0, 1'h0);
      hchk(1'h1, 1'h0, 1'h0, 32'h000C8000 + i * 32'h00008000, 1'h1, 1'h0);
      hchk(1'h1, 1'h0, 1'h1, 32'h000C0000 + i * 32'h00008000, 1'h1, 1'h0);
    end
    apb(1'h1, 8'h26, 32'h00000080);
    hchk(1'h1, 1'h0, 1'h1, 32'h000EFFFF, 1'h0, 1'h0);
    hchk(1'h1, 1'h1, 1'h0, 32'h000EFFFF, 1'h1, 1'h0);
    apb(1'h0, 8'h2E, '0);
    chk(q, 32'h00000000);
    // Low nibble always written as zero by software
    for (i = 0; i < 4; i++) begin
      apb(1'h1, 8'h2E, 32'h00000010 << i);
      hchk(1'h1, 1'h0, 1'h0, 32'h000C0000 + i * 32'h00010000, 1'h1, 1'h1);
      hchk(1'h1, 1'h0, 1'h0, 32'h000D0000 + i * 32'h00010000, 1'h1, 1'h0);
    end
    apb(1'h1, 8'h2F, '0);
    apb(1'h0, 8'h2F, '0);
    chk(q, 32'h00000000);
    // A write without its low byte strobe leaves the register alone
    strb <= 4'h0;
    apb(1'h1, 8'h2D, '0);
    strb <= 4'hF;
    apb(1'h0, 8'h2D, '0);
    chk(q, 32'h000000E0);
    // Mode changes only while both lines are low
    apb(1'h1, 8'h2D, '0);
    @(posedge clk);
    kin <= 1'h1;
    min <= 1'h1;
    @(posedge clk);
    kin <= 1'h0;
    min <= 1'h0;
    hchk(1'h1, 1'h1, 1'h1, 32'h00000060, 1'h1, 1'h0);
    chk({kout, mout}, 2'h3);
    hchk(1'h1, 1'h1, 1'h0, 32'h00000060, 1'h1, 1'h0);
    hchk(1'h0, 1'h0, 1'h0, '0, 1'h1, 1'h0);
    chk({kout, mout}, 2'h0);
    apb(1'h1, 8'h2D, 32'h000000C0);
    @(posedge clk);
    kin <= 1'h1;
    min <= 1'h1;
    #1;
    chk({kout, mout}, 2'h3);
    @(posedge clk);
    kin <= 1'h0;
    #1;
    chk({kout, mout}, 2'h1);
    @(posedge clk);
    min <= 1'h0;
    #1;
    chk(mout, 1'h0);
    // Reset in mid-run returns written registers to their reset values
    @(posedge clk);
    reset_n <= 1'h0;
    @(posedge clk);
    reset_n <= 1'h1;
    apb(1'h0, 8'h2E, '0);
    chk(q, 32'h00000000);
    apb(1'h0, 8'h26, '0);
    chk(q, 32'h00000000);
    test_done;
  end
endmodule

// ---- rscl_host_model.sv ----
/* Host processor model issuing memory and I/O cycles.
   Assumes the bench calls go() and that clk runs. */
`timescale 1ns/10ps
module rscl_host_model (
  // Clock
  input wire logic clk,
  // Cycle towards the block
  output rscl_pkg::rscl_cycle_type cyc
);
  initial cyc = '0;
  // Idle bus shows the inverted address, so a stale decode cannot pass for a hit
  task go(input logic a, io, w, input logic [31:0] ad);
    @(posedge clk);
    cyc <= a ? {a, io, w, ad} : {3'h0, ~cyc.addr};
  endtask
endmodule

// ---- rscl_params.svh ----
/*
  Offsets, field positions, reset values and address windows of the
  ROM select, cacheability and interrupt latch register bank.
  Assumes inclusion by its bare name from the top module.
*/
`ifndef RSCL_PARAMS_SVH
`define RSCL_PARAMS_SVH

// Register indices; byte address on APB is four times the index
`define RSCL_IDX_ROM_WRITE 8'h26
`define RSCL_IDX_ROM_AREA 8'h2D
`define RSCL_IDX_CACHE_AREA 8'h2E
`define RSCL_IDX_RESERVED 8'h2F

// Field positions
`define RSCL_BIT_ROM_WRITE_EN 7
`define RSCL_BIT_MOUSE_PASS 7
`define RSCL_BIT_KBD_PASS 6
`define RSCL_ROM_AREA_MSB 5
`define RSCL_CACHE_AREA_LSB 4

// Reset values
`define RSCL_RST_ROM_WRITE 8'h00
`define RSCL_RST_ROM_AREA 8'hC0
`define RSCL_RST_CACHE_AREA 8'h00
`define RSCL_RST_RESERVED 8'h00

// Address windows
`define RSCL_ROM_BASE 32'h000C0000
`define RSCL_ROM_TOP 32'h000EFFFF
`define RSCL_CACHE_BASE 32'h000C0000
`define RSCL_CACHE_TOP 32'h000FFFFF
`define RSCL_KBD_DATA_PORT 16'h0060

`endif

// ---- rscl_pkg.sv ----
/*
  Types shared by the register bank: the host cycle carrier and the
  decoded register selection.
  Assumes rscl_params.svh for the numeric constants.
*/
package rscl_pkg;

  // One host processor cycle as seen by the decoders
  typedef struct packed {
    logic active;
    logic is_io;
    logic is_write;
    logic [31:0] addr;
  } rscl_cycle_type;

  // Which register an APB address selects
  typedef enum {
    RSCL_SEL_NONE,
    RSCL_SEL_ROM_WRITE,
    RSCL_SEL_ROM_AREA,
    RSCL_SEL_CACHE_AREA,
    RSCL_SEL_RESERVED
  } rscl_sel_type;

endpackage

// ---- rscl_top.sv ----
/*
  ROM chip select, internal cache area and interrupt latch register bank
  with its APB slave and the logic the registers steer.
  Assumes host cycle fields and interrupt lines synchronous to clk, and
  an APB master that holds each request until pready is sampled high.
*/
// Functional notes
// R1: Bit 7 zero latches mouse interrupt, resets one
// R2: Port 60h I/O read clears held mouse interrupt
// R3: Bit 6 likewise for keyboard interrupt, resets one
// R4: Bits 5:0 enable ROM select per 32KB area
// R5: Bit 0 at C0000h, ascending, bit 5 E8000h
// R6: ROM select on writes needs ROM write enable
// R7: Bits 7:4 mark 64KB areas internally cacheable
// R8: Bit 4 C0000h up to bit 7 F0000h
// R9: Software writes zeros to reserved bits
// R10: Active-low ROM select decoded from current cycle
`timescale 1ns/10ps
`include "rscl_params.svh"

module rscl_top (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Host processor cycle
  input wire logic host_cycle_active,
  input wire logic host_cycle_is_io,
  input wire logic host_cycle_is_write,
  input wire logic [31:0] host_cycle_addr,
  // Interrupt lines in and out
  input wire logic mouse_interrupt_in,
  input wire logic keyboard_interrupt_in,
  output logic mouse_interrupt,
  output logic keyboard_interrupt,
  // Decoded memory controls
  output logic rom_select_n,
  output logic l1_cacheable
);

  ////////////////////////////////////////////////////////////////////////
  // Decode helpers

  // Index of the 32KB ROM area that holds an address
  function automatic logic [2:0] rom_area_of(input logic [31:0] a);
    logic [31:0] off;
    off = a - `RSCL_ROM_BASE;
    rom_area_of = off[17:15];
  endfunction

  // Index of the 64KB cacheable area that holds an address
  function automatic logic [1:0] cache_area_of(input logic [31:0] a);
    logic [31:0] off;
    off = a - `RSCL_CACHE_BASE;
    cache_area_of = off[17:16];
  endfunction

  // Register selected by an APB byte address
  function automatic rscl_pkg::rscl_sel_type sel_of(input logic [31:0] a);
    logic [7:0] idx;
    idx = a[9:2];
    sel_of = rscl_pkg::RSCL_SEL_NONE;
    if (a[31:10] == 22'h000000 && a[1:0] == 2'h0) begin
      case (idx)
        `RSCL_IDX_ROM_WRITE: sel_of = rscl_pkg::RSCL_SEL_ROM_WRITE;
        `RSCL_IDX_ROM_AREA: sel_of = rscl_pkg::RSCL_SEL_ROM_AREA;
        `RSCL_IDX_CACHE_AREA: sel_of = rscl_pkg::RSCL_SEL_CACHE_AREA;
        `RSCL_IDX_RESERVED: sel_of = rscl_pkg::RSCL_SEL_RESERVED;
        default: sel_of = rscl_pkg::RSCL_SEL_NONE;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0] rom_write_control_reg;
  logic [7:0] rom_area_select_and_irq_latch_reg;
  logic [7:0] internal_cache_area_enable_reg;
  logic [7:0] reserved_zero_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;

  logic [7:0] rom_write_control_next;
  logic [7:0] rom_area_select_and_irq_latch_next;
  logic [7:0] internal_cache_area_enable_next;
  logic [7:0] reserved_zero_next;
  logic [31:0] prdata_next;
  logic pslverr_next;

  ////////////////////////////////////////////////////////////////////////
  // APB slave

  // Zero wait states: read data is captured in the setup cycle so that
  // it comes from a flip-flop during the access phase
  rscl_pkg::rscl_sel_type apb_sel;
  assign apb_sel = sel_of(paddr);
  wire apb_setup = psel & ~penable;
  wire apb_access = psel & penable;
  wire apb_write = apb_access & pwrite & pstrb[0];
  wire apb_mapped = (apb_sel != rscl_pkg::RSCL_SEL_NONE);

  wire wr_rom_write = apb_write & (apb_sel == rscl_pkg::RSCL_SEL_ROM_WRITE);
  wire wr_rom_area = apb_write & (apb_sel == rscl_pkg::RSCL_SEL_ROM_AREA);
  wire wr_cache_area = apb_write & (apb_sel == rscl_pkg::RSCL_SEL_CACHE_AREA);
  wire wr_reserved = apb_write & (apb_sel == rscl_pkg::RSCL_SEL_RESERVED);

  // Only the enable bit of the ROM write control register exists
  wire [7:0] rom_write_mask = 8'h80;

  // Reserved bits outside the ROM write control register are stored as written;
  // a nonzero write has no effect on the decoders, software is expected to keep them zero [R9]
  assign rom_write_control_next = wr_rom_write ?
    (pwdata[7:0] & rom_write_mask) : rom_write_control_reg;
  assign rom_area_select_and_irq_latch_next = wr_rom_area ?
    pwdata[7:0] : rom_area_select_and_irq_latch_reg;
  assign internal_cache_area_enable_next = wr_cache_area ?
    pwdata[7:0] : internal_cache_area_enable_reg;
  assign reserved_zero_next = wr_reserved ? pwdata[7:0] : reserved_zero_reg;

  wire [7:0] read_byte =
    (apb_sel == rscl_pkg::RSCL_SEL_ROM_WRITE) ? rom_write_control_reg :
    (apb_sel == rscl_pkg::RSCL_SEL_ROM_AREA) ? rom_area_select_and_irq_latch_reg :
    (apb_sel == rscl_pkg::RSCL_SEL_CACHE_AREA) ? internal_cache_area_enable_reg :
    (apb_sel == rscl_pkg::RSCL_SEL_RESERVED) ? reserved_zero_reg :
    8'h00;

  assign prdata_next = apb_setup ? {24'h000000, read_byte} : prdata_reg;
  assign pslverr_next = apb_setup ? ~apb_mapped : pslverr_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rom_write_control_reg <= `RSCL_RST_ROM_WRITE;
      rom_area_select_and_irq_latch_reg <= `RSCL_RST_ROM_AREA; // [R1] [R3] [R4]
      internal_cache_area_enable_reg <= `RSCL_RST_CACHE_AREA; // [R7]
      reserved_zero_reg <= `RSCL_RST_RESERVED;
      prdata_reg <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end else begin
      rom_write_control_reg <= rom_write_control_next;
      rom_area_select_and_irq_latch_reg <= rom_area_select_and_irq_latch_next;
      internal_cache_area_enable_reg <= internal_cache_area_enable_next;
      reserved_zero_reg <= reserved_zero_next;
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = 1'b1;
  // Error is reported only in the access phase
  assign pslverr = apb_access & pslverr_reg;

  ////////////////////////////////////////////////////////////////////////
  // Host cycle decode

  wire rscl_pkg::rscl_cycle_type cycle = '{
    active: host_cycle_active,
    is_io: host_cycle_is_io,
    is_write: host_cycle_is_write,
    addr: host_cycle_addr
  };

  wire mem_cycle = cycle.active & ~cycle.is_io;
  wire kbd_data_read = cycle.active & cycle.is_io & ~cycle.is_write &
    (cycle.addr[15:0] == `RSCL_KBD_DATA_PORT); // [R2]

  ////////////////////////////////////////////////////////////////////////
  // ROM chip select

  wire in_rom_window = (cycle.addr >= `RSCL_ROM_BASE) &&
    (cycle.addr <= `RSCL_ROM_TOP);
  wire [2:0] rom_area = rom_area_of(cycle.addr); // [R5]
  wire [5:0] rom_area_en =
    rom_area_select_and_irq_latch_reg[`RSCL_ROM_AREA_MSB:0];
  wire rom_area_hit = in_rom_window & rom_area_en[rom_area]; // [R4]
  wire rom_write_en = rom_write_control_reg[`RSCL_BIT_ROM_WRITE_EN];
  // Writes reach the ROM only when flash updates are allowed
  wire rom_dir_ok = ~cycle.is_write | rom_write_en; // [R6]

  // Pure decode of the live cycle so no wait state is added
  assign rom_select_n = ~(mem_cycle & rom_area_hit & rom_dir_ok); // [R10]

  ////////////////////////////////////////////////////////////////////////
  // Internal cache area

  wire in_cache_window = (cycle.addr >= `RSCL_CACHE_BASE) &&
    (cycle.addr <= `RSCL_CACHE_TOP);
  wire [1:0] cache_area = cache_area_of(cycle.addr);
  wire [3:0] cache_area_en =
    internal_cache_area_enable_reg[7:`RSCL_CACHE_AREA_LSB];
  // Bit 4 is C0000h, bit 7 is F0000h [R8]
  assign l1_cacheable = mem_cycle & in_cache_window &
    cache_area_en[cache_area]; // [R7]

  ////////////////////////////////////////////////////////////////////////
  // Interrupt latches

  // Index 0 is the keyboard line, index 1 the mouse line
  wire [1:0] irq_in = {mouse_interrupt_in, keyboard_interrupt_in};
  wire [1:0] irq_pass = {
    rom_area_select_and_irq_latch_reg[`RSCL_BIT_MOUSE_PASS],
    rom_area_select_and_irq_latch_reg[`RSCL_BIT_KBD_PASS]
  };
  logic [1:0] irq_out;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_irq
      logic held_reg;
      logic held_next;

      // Pass-through keeps the flop following the line, so switching to
      // latched mode while the line is high shows no false low cycle.
      // A rising line in the same cycle as the clearing read stays held,
      // so an interrupt raised during the data read is not lost
      assign held_next = irq_pass[gi] ? irq_in[gi] :
        (irq_in[gi] ? 1'b1 : (kbd_data_read ? 1'b0 : held_reg)); // [R2] [R3]

      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          held_reg <= 1'b0;
        end else begin
          held_reg <= held_next;
        end
      end

      // Pass-through mode forwards the live line unlatched
      assign irq_out[gi] = irq_pass[gi] ? irq_in[gi] : held_reg; // [R1] [R3]
    end
  endgenerate

  assign keyboard_interrupt = irq_out[0];
  assign mouse_interrupt = irq_out[1];

endmodule

// ---- rscl_top_props.sv ----
/* Checker for the decode and interrupt outputs of the register bank.
   Assumes it is bound to rscl_top and sees only that module's ports. */
`timescale 1ns/10ps
module rscl_top_props (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Host cycle
  input wire logic host_cycle_active,
  input wire logic host_cycle_is_io,
  input wire logic host_cycle_is_write,
  input wire logic [31:0] host_cycle_addr,
  // Interrupts and decode
  input wire logic mouse_interrupt_in,
  input wire logic keyboard_interrupt_in,
  input wire logic mouse_interrupt,
  input wire logic keyboard_interrupt,
  input wire logic rom_select_n,
  input wire logic l1_cacheable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire mem_cyc = host_cycle_active && !host_cycle_is_io;
  wire rd60 = host_cycle_active && host_cycle_is_io && !host_cycle_is_write
    && host_cycle_addr[15:0] == 16'h0060;
  wire out_rom = host_cycle_addr < 32'h000C0000 || host_cycle_addr > 32'h000EFFFF;
  wire out_l1 = host_cycle_addr < 32'h000C0000 || host_cycle_addr > 32'h000FFFFF;
  io_rom_quiet_a: assert property (!mem_cyc |-> rom_select_n)
    else $error("rom select outside memory cycle");
  rom_window_a: assert property (mem_cyc && out_rom |-> rom_select_n)
    else $error("rom select outside rom window");
  cache_window_a: assert property (!mem_cyc || out_l1 |-> !l1_cacheable)
    else $error("cacheable outside cache window");
  mouse_hold_a: assert property (
    mouse_interrupt_in |=> mouse_interrupt || !mouse_interrupt_in)
    else $error("mouse interrupt lost");
  kbd_hold_a: assert property (
    keyboard_interrupt_in |=> keyboard_interrupt || !keyboard_interrupt_in)
    else $error("keyboard interrupt lost");
  mouse_clear_a: assert property (
    rd60 && !mouse_interrupt_in |=> !mouse_interrupt || mouse_interrupt_in)
    else $error("mouse interrupt not cleared");
  kbd_clear_a: assert property (
    rd60 && !keyboard_interrupt_in |=> !keyboard_interrupt || keyboard_interrupt_in)
    else $error("keyboard interrupt not cleared");
  kbd_cause_a: assert property (
    $rose(keyboard_interrupt) |-> keyboard_interrupt_in || $past(keyboard_interrupt_in))
    else $error("keyboard interrupt without cause");
  cover property (!rom_select_n);
  cover property (l1_cacheable);
  cover property (rd60 && keyboard_interrupt);
endmodule
bind rscl_top rscl_top_props rscl_top_props_inst (
  .clk(clk),
  .reset_n(reset_n),
  .host_cycle_active(host_cycle_active),
  .host_cycle_is_io(host_cycle_is_io),
  .host_cycle_is_write(host_cycle_is_write),
  .host_cycle_addr(host_cycle_addr),
  .mouse_interrupt_in(mouse_interrupt_in),
  .keyboard_interrupt_in(keyboard_interrupt_in),
  .mouse_interrupt(mouse_interrupt),
  .keyboard_interrupt(keyboard_interrupt),
  .rom_select_n(rom_select_n),
  .l1_cacheable(l1_cacheable)
);
